// *** inc/irc_defs.svh ***
// Purpose: Constants of the register command link.
// Assumes: Included by the package and both ends.
// Notes: Summary of operation below.
//
// Summary of operation
// - Humidity read returns code, two, high, low, CRC
// - Info read at 0x08, seven bytes, then CRC
// - Host writes status with 0x10, 0x0F, one
// - Write reply echoes code, start, count, new CRC
// - Host writes user one with 0x10, 0x10, two
// - Only frames addressed 0xB8 plus write answered
// - CRC travels low byte first, high second
// - Errors 0x80 function, 0x81 read, 0x82 range
// - Errors 0x83 CRC mismatch, 0x84 write prohibited
// - Read reply: code, length, register bytes, CRC
// - Writes only 0x0F-0x13; status written alone
// - At most ten registers per transaction
`ifndef IRC_DEFS_SVH
`define IRC_DEFS_SVH
`define IRC_BUS_ADDR 8'hB8
`define IRC_FN_READ 8'h03
`define IRC_FN_WRITE 8'h10
`define IRC_ERR_FUNC 8'h80
`define IRC_ERR_RADDR 8'h81
`define IRC_ERR_RANGE 8'h82
`define IRC_ERR_CRC 8'h83
`define IRC_ERR_WPROT 8'h84
`define IRC_CRC_INIT 16'hFFFF
`define IRC_CRC_POLY 16'hA001
`define IRC_MAX_REGS 8'h0A
`define IRC_NUM_REGS 9'h020
`define IRC_WR_FIRST 8'h0F
`define IRC_WR_END 9'h014
`define IRC_WR_NUM 5
`define IRC_RX_BYTES 15
`define IRC_WR_OVH 8'h05
`define IRC_RD_LEN 4'h3
`define IRC_A_HUM_H 8'h00
`define IRC_A_HUM_L 8'h01
`define IRC_A_TMP_H 8'h02
`define IRC_A_TMP_L 8'h03
`define IRC_A_MOD_H 8'h08
`define IRC_A_MOD_L 8'h09
`define IRC_A_VER 8'h0A
`define IRC_A_ID3 8'h0B
`define IRC_A_ID2 8'h0C
`define IRC_A_ID1 8'h0D
`define IRC_A_ID0 8'h0E
`endif

// *** inc/irc_pkg.sv ***
// Purpose: Types and CRC step shared by both ends.
// Assumes: irc_defs.svh on the include path.
// Notes: One-hot state codes.
`include "irc_defs.svh"
package irc_pkg;
  typedef enum logic [2:0] {
    IRC_D_RX = 3'h1,
    IRC_D_EVAL = 3'h2,
    IRC_D_TX = 3'h4
  } irc_dev_st_t;

  typedef enum logic [2:0] {
    IRC_H_IDLE = 3'h1,
    IRC_H_SEND = 3'h2,
    IRC_H_RECV = 3'h4
  } irc_host_st_t;

  // One byte of the reflected CRC-16
  function automatic logic [15:0] irc_crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++)
    begin
      r = r[0] ? ((r >> 1) ^ `IRC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// *** inc/irc_link_if.sv ***
// Purpose: Byte-level frame link between host and device.
// Assumes: One clock shared by both ends.
// Notes: first marks the bus address byte of a request.
`timescale 1ns/10ps
interface irc_link_if;
  logic h2d_valid;
  logic h2d_ready;
  logic [7:0] h2d_data;
  logic h2d_first;
  logic h2d_last;
  logic d2h_valid;
  logic d2h_ready;
  logic [7:0] d2h_data;
  logic d2h_last;
  modport dev (
    input h2d_valid, h2d_data, h2d_first, h2d_last, d2h_ready,
    output h2d_ready, d2h_valid, d2h_data, d2h_last
  );
  modport host (
    output h2d_valid, h2d_data, h2d_first, h2d_last, d2h_ready,
    input h2d_ready, d2h_valid, d2h_data, d2h_last
  );
endinterface

// *** rtl/irc_device.sv ***
// Purpose: Sensor end: decodes register frames and answers them.
// Assumes: Host holds each byte until h2d_ready; frame ends on h2d_last.
// Notes: Measurements are snapshotted when a frame is evaluated.
`timescale 1ns/10ps
`include "irc_defs.svh"
module irc_device
  import irc_pkg::*;
#(
  parameter logic [15:0] MODEL = 16'h0A5A, // Arbitrary value
  parameter logic [7:0] VERSION = 8'h01, // Arbitrary value
  parameter logic [31:0] DEV_ID = 32'h1234_5678 // Arbitrary value
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Link
  irc_link_if.dev link,
  // Measurements
  input wire logic [15:0] hum_i,
  input wire logic [15:0] temp_i,
  // Writable register contents
  output logic [7:0] status_o,
  output logic [15:0] user1_o,
  output logic [15:0] user2_o,
  // Frame events
  output logic wr_done_o,
  output logic err_o,
  output logic [7:0] err_code_o
);
  irc_dev_st_t st, next_st;
  logic [7:0] rx_buf [0:`IRC_RX_BYTES-1];
  logic [7:0] next_rx_buf [0:`IRC_RX_BYTES-1];
  logic [3:0] rx_n, next_rx_n;
  logic drop, next_drop;
  logic ovf, next_ovf;
  logic [15:0] crc_run, crc_d1, crc_d2, next_crc_run, next_crc_d1, next_crc_d2;
  logic [7:0] wr_reg [0:`IRC_WR_NUM-1];
  logic [7:0] next_wr_reg [0:`IRC_WR_NUM-1];
  logic [15:0] hum_q, temp_q, next_hum_q, next_temp_q;
  logic [7:0] rsp_b0, rsp_b1, rsp_b2, next_rsp_b0, next_rsp_b1, next_rsp_b2;
  logic rsp_rd, next_rsp_rd;
  logic [3:0] tx_len, tx_idx, next_tx_len, next_tx_idx;
  logic [15:0] crc_tx, next_crc_tx;
  logic next_wr_done, next_err;
  logic [7:0] next_err_code;
  logic [7:0] tx_byte;
  logic [7:0] fn, start, cnt;
  logic [8:0] end_addr;
  logic [7:0] code;

  // Register map as seen by reads
  function automatic logic [7:0] reg_rd(input logic [7:0] a);
    case (a)
      `IRC_A_HUM_H: reg_rd = hum_q[15:8];
      `IRC_A_HUM_L: reg_rd = hum_q[7:0];
      `IRC_A_TMP_H: reg_rd = temp_q[15:8];
      `IRC_A_TMP_L: reg_rd = temp_q[7:0];
      `IRC_A_MOD_H: reg_rd = MODEL[15:8];
      `IRC_A_MOD_L: reg_rd = MODEL[7:0];
      `IRC_A_VER: reg_rd = VERSION;
      `IRC_A_ID3: reg_rd = DEV_ID[31:24];
      `IRC_A_ID2: reg_rd = DEV_ID[23:16];
      `IRC_A_ID1: reg_rd = DEV_ID[15:8];
      `IRC_A_ID0: reg_rd = DEV_ID[7:0];
      default:
      begin
        if (a >= `IRC_WR_FIRST && {1'b0, a} < `IRC_WR_END)
          reg_rd = wr_reg[3'(a - `IRC_WR_FIRST)];
        else
          reg_rd = 8'h00;
      end
    endcase
  endfunction

  assign fn = rx_buf[0];
  assign start = rx_buf[1];
  assign cnt = rx_buf[2];
  assign end_addr = {1'b0, start} + {1'b0, cnt};

  // Error classification of a complete frame
  always_comb
  begin
    code = 8'h00;
    if (fn == `IRC_FN_READ)
    begin
      if (ovf || rx_n != `IRC_RD_LEN)
        code = `IRC_ERR_RANGE;
      else if (cnt == 8'h00 || cnt > `IRC_MAX_REGS || end_addr > `IRC_NUM_REGS)
        code = `IRC_ERR_RADDR;
    end
    else if (fn == `IRC_FN_WRITE)
    begin
      if (ovf || rx_n < 4'h5 || {4'h0, rx_n} != cnt + `IRC_WR_OVH)
        code = `IRC_ERR_RANGE;
      else if (crc_d2 != {rx_buf[4'(rx_n - 4'h1)], rx_buf[4'(rx_n - 4'h2)]})
        code = `IRC_ERR_CRC;
      else if (cnt == 8'h00 || cnt > `IRC_MAX_REGS)
        code = `IRC_ERR_RANGE;
      else if (start < `IRC_WR_FIRST || end_addr > `IRC_WR_END ||
               (start == `IRC_WR_FIRST && cnt != 8'h01))
        code = `IRC_ERR_WPROT;
    end
    else
      code = `IRC_ERR_FUNC;
  end

  // Byte on the reply line
  always_comb
  begin
    if (tx_idx == 4'h0)
      tx_byte = rsp_b0;
    else if (tx_idx == 4'h1)
      tx_byte = rsp_b1;
    else if (tx_idx == tx_len)
      tx_byte = crc_tx[7:0];
    else if (tx_idx > tx_len)
      tx_byte = crc_tx[15:8];
    else if (!rsp_rd)
      tx_byte = rsp_b2;
    else
      tx_byte = reg_rd(rsp_b2 + 8'(tx_idx - 4'h2));
  end

  assign link.h2d_ready = (st == IRC_D_RX);
  assign link.d2h_valid = (st == IRC_D_TX);
  assign link.d2h_data = tx_byte;
  assign link.d2h_last = (st == IRC_D_TX) && (tx_idx > tx_len);

  always_comb
  begin
    next_st = st;
    next_rx_buf = rx_buf;
    next_rx_n = rx_n;
    next_drop = drop;
    next_ovf = ovf;
    next_crc_run = crc_run;
    next_crc_d1 = crc_d1;
    next_crc_d2 = crc_d2;
    next_wr_reg = wr_reg;
    next_hum_q = hum_q;
    next_temp_q = temp_q;
    next_rsp_b0 = rsp_b0;
    next_rsp_b1 = rsp_b1;
    next_rsp_b2 = rsp_b2;
    next_rsp_rd = rsp_rd;
    next_tx_len = tx_len;
    next_tx_idx = tx_idx;
    next_crc_tx = crc_tx;
    next_wr_done = 1'b0;
    next_err = 1'b0;
    next_err_code = err_code_o;
    case (st)
      IRC_D_RX:
      begin
        if (link.h2d_valid)
        begin
          if (link.h2d_first)
          begin
            next_drop = (link.h2d_data != `IRC_BUS_ADDR);
            next_rx_n = 4'h0;
            next_ovf = 1'b0;
            next_crc_run = `IRC_CRC_INIT;
          end
          else if (rx_n == 4'(`IRC_RX_BYTES))
            next_ovf = 1'b1;
          else
          begin
            next_rx_buf[rx_n] = link.h2d_data;
            next_rx_n = rx_n + 4'h1;
            next_crc_d2 = crc_d1;
            next_crc_d1 = crc_run;
            next_crc_run = irc_crc_step(crc_run, link.h2d_data);
          end
          if (link.h2d_last && !(link.h2d_first ? (link.h2d_data != `IRC_BUS_ADDR) : drop) &&
              !link.h2d_first)
            next_st = IRC_D_EVAL;
        end
      end
      IRC_D_EVAL:
      begin
        next_hum_q = hum_i;
        next_temp_q = temp_i;
        next_tx_idx = 4'h0;
        next_crc_tx = `IRC_CRC_INIT;
        next_st = IRC_D_TX;
        next_rsp_b0 = fn;
        next_rsp_b1 = cnt;
        next_rsp_b2 = start;
        next_rsp_rd = (code == 8'h00) && (fn == `IRC_FN_READ);
        next_tx_len = 4'(cnt) + 4'h2;
        if (code != 8'h00)
        begin
          next_rsp_b1 = code;
          next_tx_len = 4'h2;
          next_err = 1'b1;
          next_err_code = code;
        end
        else if (fn == `IRC_FN_WRITE)
        begin
          next_rsp_b1 = start;
          next_rsp_b2 = cnt;
          next_tx_len = 4'h3;
          next_wr_done = 1'b1;
          for (int i = 0; i < `IRC_WR_NUM; i++)
          begin
            if ({1'b0, `IRC_WR_FIRST} + 9'(i) >= {1'b0, start} && {1'b0, `IRC_WR_FIRST} + 9'(i) < end_addr)
              next_wr_reg[i] = rx_buf[4'(8'h03 + `IRC_WR_FIRST + 8'(i) - start)];
          end
        end
      end
      IRC_D_TX:
      begin
        if (link.d2h_ready)
        begin
          next_tx_idx = tx_idx + 4'h1;
          if (tx_idx < tx_len)
            next_crc_tx = irc_crc_step(crc_tx, tx_byte);
          if (tx_idx > tx_len)
            next_st = IRC_D_RX;
        end
      end
      default: next_st = IRC_D_RX;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st <= IRC_D_RX;
      for (int i = 0; i < `IRC_RX_BYTES; i++)
        rx_buf[i] <= 8'h00;
      for (int i = 0; i < `IRC_WR_NUM; i++)
        wr_reg[i] <= 8'h00;
      rx_n <= 4'h0;
      drop <= 1'b1;
      ovf <= 1'b0;
      crc_run <= `IRC_CRC_INIT;
      crc_d1 <= `IRC_CRC_INIT;
      crc_d2 <= `IRC_CRC_INIT;
      hum_q <= 16'h0000;
      temp_q <= 16'h0000;
      rsp_b0 <= 8'h00;
      rsp_b1 <= 8'h00;
      rsp_b2 <= 8'h00;
      rsp_rd <= 1'b0;
      tx_len <= 4'h0;
      tx_idx <= 4'h0;
      crc_tx <= `IRC_CRC_INIT;
      wr_done_o <= 1'b0;
      err_o <= 1'b0;
      err_code_o <= 8'h00;
    end
    else
    begin
      st <= next_st;
      rx_buf <= next_rx_buf;
      wr_reg <= next_wr_reg;
      rx_n <= next_rx_n;
      drop <= next_drop;
      ovf <= next_ovf;
      crc_run <= next_crc_run;
      crc_d1 <= next_crc_d1;
      crc_d2 <= next_crc_d2;
      hum_q <= next_hum_q;
      temp_q <= next_temp_q;
      rsp_b0 <= next_rsp_b0;
      rsp_b1 <= next_rsp_b1;
      rsp_b2 <= next_rsp_b2;
      rsp_rd <= next_rsp_rd;
      tx_len <= next_tx_len;
      tx_idx <= next_tx_idx;
      crc_tx <= next_crc_tx;
      wr_done_o <= next_wr_done;
      err_o <= next_err;
      err_code_o <= next_err_code;
    end
  end

  assign status_o = wr_reg[0];
  assign user1_o = {wr_reg[1], wr_reg[2]};
  assign user2_o = {wr_reg[3], wr_reg[4]};
endmodule

// *** rtl/irc_host.sv ***
// Purpose: Host end: sends one read or write frame, collects the reply.
// Assumes: Caller gives legal start and count for writes.
// Notes: Reply bytes after the function code, CRC bytes excluded, land in rsp_data_o.
`timescale 1ns/10ps
`include "irc_defs.svh"
module irc_host
  import irc_pkg::*;
#(
  parameter logic [7:0] TARGET = `IRC_BUS_ADDR
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Link
  irc_link_if.host link,
  // Command
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_start_i,
  input wire logic [7:0] cmd_count_i,
  input wire logic [79:0] cmd_data_i,
  output logic cmd_ready_o,
  // Reply
  output logic rsp_valid_o,
  output logic [7:0] rsp_func_o,
  output logic [87:0] rsp_data_o,
  output logic [3:0] rsp_len_o,
  output logic rsp_crc_ok_o
);
  irc_host_st_t st, next_st;
  logic wr, next_wr;
  logic [7:0] start, cnt, next_start, next_cnt;
  logic [79:0] data, next_data;
  logic [3:0] idx, next_idx;
  logic [15:0] crc, next_crc;
  logic [7:0] rb [0:11];
  logic [7:0] next_rb [0:11];
  logic [3:0] rn, next_rn;
  logic next_rsp_valid, next_crc_ok;
  logic [3:0] next_rsp_len;
  logic [3:0] n_data;
  logic [7:0] byte_o;
  logic is_last;

  assign n_data = wr ? 4'(cnt) : 4'h0;
  assign is_last = wr ? (idx == n_data + 4'h5) : (idx == 4'h3);

  always_comb
  begin
    case (idx)
      4'h0: byte_o = TARGET;
      4'h1: byte_o = wr ? `IRC_FN_WRITE : `IRC_FN_READ;
      4'h2: byte_o = start;
      4'h3: byte_o = cnt;
      default:
      begin
        if (idx < n_data + 4'h4)
          byte_o = data[8*(idx-4'h4) +: 8];
        else if (idx == n_data + 4'h4)
          byte_o = crc[7:0];
        else
          byte_o = crc[15:8];
      end
    endcase
  end

  assign cmd_ready_o = (st == IRC_H_IDLE);
  assign link.h2d_valid = (st == IRC_H_SEND);
  assign link.h2d_data = byte_o;
  assign link.h2d_first = (st == IRC_H_SEND) && (idx == 4'h0);
  assign link.h2d_last = (st == IRC_H_SEND) && is_last;
  assign link.d2h_ready = (st == IRC_H_RECV);

  always_comb
  begin
    next_st = st;
    next_wr = wr;
    next_start = start;
    next_cnt = cnt;
    next_data = data;
    next_idx = idx;
    next_crc = crc;
    next_rb = rb;
    next_rn = rn;
    next_rsp_valid = 1'b0;
    next_crc_ok = rsp_crc_ok_o;
    next_rsp_len = rsp_len_o;
    case (st)
      IRC_H_IDLE:
      begin
        if (cmd_valid_i)
        begin
          next_wr = cmd_write_i;
          next_start = cmd_start_i;
          next_cnt = cmd_count_i;
          next_data = cmd_data_i;
          next_idx = 4'h0;
          next_crc = `IRC_CRC_INIT;
          next_st = IRC_H_SEND;
        end
      end
      IRC_H_SEND:
      begin
        if (link.h2d_ready)
        begin
          next_idx = idx + 4'h1;
          if (idx != 4'h0 && idx < n_data + 4'h4)
            next_crc = irc_crc_step(crc, byte_o);
          if (is_last)
          begin
            next_st = IRC_H_RECV;
            next_rn = 4'h0;
            next_crc = `IRC_CRC_INIT;
            for (int i = 0; i < 12; i++)
              next_rb[i] = 8'h00;
          end
        end
      end
      IRC_H_RECV:
      begin
        if (link.d2h_valid)
        begin
          if (rn < 4'hC)
            next_rb[rn] = link.d2h_data;
          next_rn = rn + 4'h1;
          next_crc = irc_crc_step(crc, link.d2h_data);
          if (link.d2h_last)
          begin
            next_rsp_valid = 1'b1;
            next_rsp_len = rn - 4'h1;
            // Low byte then high byte folded in leaves a zero residue; no byte store needed
            next_crc_ok = (next_crc == 16'h0000);
            if (rn < 4'hC)
              next_rb[rn] = 8'h00;
            if (rn > 4'h0 && rn < 4'hD)
              next_rb[4'(rn - 4'h1)] = 8'h00;
            next_st = IRC_H_IDLE;
          end
        end
      end
      default: next_st = IRC_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st <= IRC_H_IDLE;
      wr <= 1'b0;
      start <= 8'h00;
      cnt <= 8'h00;
      data <= 80'h0;
      idx <= 4'h0;
      crc <= `IRC_CRC_INIT;
      for (int i = 0; i < 12; i++)
        rb[i] <= 8'h00;
      rn <= 4'h0;
      rsp_valid_o <= 1'b0;
      rsp_crc_ok_o <= 1'b0;
      rsp_len_o <= 4'h0;
    end
    else
    begin
      st <= next_st;
      wr <= next_wr;
      start <= next_start;
      cnt <= next_cnt;
      data <= next_data;
      idx <= next_idx;
      crc <= next_crc;
      rb <= next_rb;
      rn <= next_rn;
      rsp_valid_o <= next_rsp_valid;
      rsp_crc_ok_o <= next_crc_ok;
      rsp_len_o <= next_rsp_len;
    end
  end

  assign rsp_func_o = rb[0];
  for (genvar g = 0; g < 11; g++)
  begin : g_pack
    assign rsp_data_o[8*g +: 8] = rb[g+1];
  end
endmodule

// *** verif/irc_link_assertions.sv ***
// Purpose: Link checks between the host and device ends.
// Assumes: Host end takes reply bytes as offered.
// Notes: Reply CRC is recomputed here from the reply bytes.
`timescale 1ns/10ps
module irc_link_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Request
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_first,
  input wire logic h2d_last,
  // Reply
  input wire logic d2h_valid,
  input wire logic d2h_ready,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_last
);
  logic [15:0] c0, c1;
  logic [7:0] lb, fn, st, cn;
  logic [4:0] ri;
  logic [3:0] di;
  wire rx = h2d_valid && h2d_ready;
  wire tx = d2h_valid && d2h_ready;
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++)
    begin
      r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
    end
    return r;
  endfunction
  // Request header capture and running reply CRC
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      c0 <= 16'hFFFF;
      ri <= 5'h00;
      di <= 4'h0;
    end
    else
    begin
      if (rx)
      begin
        ri <= h2d_first ? 5'h01 : ri + 5'h01;
        if (ri == 5'h01) fn <= h2d_data;
        if (ri == 5'h02) st <= h2d_data;
        if (ri == 5'h03) cn <= h2d_data;
      end
      if (tx)
      begin
        c1 <= c0;
        c0 <= d2h_last ? 16'hFFFF : step(c0, d2h_data);
        lb <= d2h_data;
        di <= d2h_last ? 4'h0 : di + 4'h1;
      end
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_REPLY_DELAY: assert property (rx && h2d_last |=> !h2d_ready ##1 d2h_valid)
    else $error("Reply did not start two cycles after the request");
  AST_NO_UNASKED: assert property ($rose(d2h_valid) |-> $past(rx && h2d_last, 2))
    else $error("Reply started without a request");
  AST_FUNC_ECHO: assert property (tx && di == 4'h0 |-> d2h_data == fn)
    else $error("Reply function code differs from request");
  AST_READ_LEN: assert property (tx && di == 4'h1 && fn == 8'h03 |-> d2h_data == cn || d2h_data inside {8'h81, 8'h82})
    else $error("Read reply length byte wrong");
  AST_WRITE_ECHO: assert property (tx && di == 4'h1 && fn == 8'h10 |-> d2h_data == st || d2h_data inside {[8'h82:8'h84]})
    else $error("Write reply start address wrong");
  AST_REPLY_SIZE: assert property (tx && d2h_last |-> di == 4'h3 || di == (fn == 8'h03 ? cn[3:0] + 4'h3 : 4'h4))
    else $error("Reply byte count wrong");
  AST_REPLY_CRC: assert property (tx && d2h_last |-> d2h_data == c1[15:8] && lb == c1[7:0])
    else $error("Reply CRC wrong or in wrong byte order");
  AST_RX_BLOCKED: assert property (d2h_valid |-> !h2d_ready)
    else $error("Request accepted while replying");
  AST_REPLY_WHOLE: assert property (d2h_valid && !(d2h_ready && d2h_last) |=> d2h_valid)
    else $error("Reply dropped before its last byte");
endmodule

// *** verif/i2c_register_command_responder_tb.sv ***
// Purpose: Host and device ends joined and exercised frame by frame.
// Assumes: A second device faces a raw byte driver for faulty frames.
// Notes: Write reply CRC bytes are fixed known examples.
`timescale 1ns/10ps
module i2c_register_command_responder_tb;
  localparam logic [15:0] MDL = 16'h4D31; // Arbitrary value
  localparam logic [7:0] VER = 8'h02; // Arbitrary value
  localparam logic [31:0] DID = 32'h9ABC_DEF0; // Arbitrary value
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cv = 1'b0;
  logic cw = 1'b0;
  logic [7:0] cs = 8'h00;
  logic [7:0] cc = 8'h00;
  logic [79:0] cd = 80'h0;
  logic [15:0] hum = 16'h0000;
  logic [15:0] tmp = 16'h1234;
  logic crdy, rv, rok, wrd, e1, e2;
  logic [3:0] rlen;
  logic [7:0] st, ec1, ec2;
  logic [15:0] u1;
  logic [15:0] u2;
  logic [7:0] rf;
  logic [87:0] rdat;
  logic [7:0] hq[$], rq[$];
  int err_total = 0;
  int n_tests = 0;
  int nw = 0, ne1 = 0, ne2 = 0, n2 = 0, l2 = 0;
  irc_link_if link();
  irc_link_if ln2();
  irc_host irc_host_inst (
    .clk_i(clk), .rstn_i(rstn), .link(link), .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_start_i(cs),
    .cmd_count_i(cc), .cmd_data_i(cd), .cmd_ready_o(crdy), .rsp_valid_o(rv), .rsp_func_o(rf),
    .rsp_data_o(rdat), .rsp_len_o(rlen), .rsp_crc_ok_o(rok));
  irc_device #(.MODEL(MDL), .VERSION(VER), .DEV_ID(DID)) irc_device_inst (
    .clk_i(clk), .rstn_i(rstn), .link(link), .hum_i(hum), .temp_i(tmp), .status_o(st),
    .user1_o(u1), .user2_o(u2), .wr_done_o(wrd), .err_o(e1), .err_code_o(ec1));
  irc_device #(.MODEL(MDL), .VERSION(VER), .DEV_ID(DID)) irc_device_inst2 (
    .clk_i(clk), .rstn_i(rstn), .link(ln2), .hum_i(hum), .temp_i(tmp), .status_o(),
    .user1_o(), .user2_o(), .wr_done_o(), .err_o(e2), .err_code_o(ec2));
  irc_link_assertions irc_link_assertions_inst (
    .clk_i(clk), .rstn_i(rstn), .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready),
    .h2d_data(link.h2d_data), .h2d_first(link.h2d_first), .h2d_last(link.h2d_last),
    .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready), .d2h_data(link.d2h_data),
    .d2h_last(link.d2h_last));
  initial
  begin
    forever #20 clk = ~clk;
  end
  // Byte and event monitor, sampled where everything is settled
  always @(negedge clk)
  begin
    if (link.h2d_valid && link.h2d_ready) hq.push_back(link.h2d_data);
    if (link.d2h_valid && link.d2h_ready) rq.push_back(link.d2h_data);
    if (ln2.d2h_valid) n2++;
    if (ln2.d2h_valid && ln2.d2h_last) l2++;
    if (wrd) nw++;
    if (e1) ne1++;
    if (e2) ne2++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic w, input logic [7:0] s, input logic [7:0] c, input logic [79:0] d);
    hq.delete();
    rq.delete();
    nw = 0;
    ne1 = 0;
    cv <= 1'b1;
    cw <= w;
    cs <= s;
    cc <= c;
    cd <= d;
    @(negedge clk);
    while (!crdy) @(negedge clk);
    @(posedge clk);
    cv <= 1'b0;
    for (int n = 0; n < 300 && rv !== 1'b1; n++) @(negedge clk);
    chk(rv, 1'b1);
    @(posedge clk);
  endtask
  task automatic exp_rsp(input logic [7:0] e[$], input int n);
    chk(rq.size(), n);
    foreach (e[i]) chk(rq[i], e[i]);
  endtask
  // Raw request on the second link, each byte held until taken
  task automatic raw(input logic [7:0] b[$]);
    n2 = 0;
    l2 = 0;
    ne2 = 0;
    foreach (b[i])
    begin
      ln2.h2d_valid <= 1'b1;
      ln2.h2d_data <= b[i];
      ln2.h2d_first <= (i == 0);
      ln2.h2d_last <= (i == b.size() - 1);
      @(negedge clk);
      while (!ln2.h2d_ready) @(negedge clk);
      @(posedge clk);
    end
    ln2.h2d_valid <= 1'b0;
  endtask
  task automatic wt2();
    for (int n = 0; n < 50 && l2 == 0; n++) @(negedge clk);
    chk(ne2, 1);
    @(posedge clk);
  endtask
  task automatic t_hum();
    hum <= 16'h1A2B;
    cmd(1'b0, 8'h00, 8'h02, 80'h0);
    chk(rlen, 4'h4);
    exp_rsp('{8'h03, 8'h02, 8'h1A, 8'h2B}, 6);
    chk(hq[0], 8'hB8);
    chk(rf, 8'h03);
    chk(rdat[15:0], 16'h1A02);
    chk(rdat[31:16], 16'h002B);
    chk(rok, 1'b1);
    cmd(1'b0, 8'h02, 8'h02, 80'h0);
    exp_rsp('{8'h03, 8'h02, 8'h12, 8'h34}, 6);
  endtask
  task automatic t_info();
    cmd(1'b0, 8'h08, 8'h07, 80'h0);
    exp_rsp('{8'h03, 8'h07, MDL[15:8], MDL[7:0], VER, DID[31:24], DID[23:16], DID[15:8], DID[7:0]}, 11);
  endtask
  task automatic t_wstat();
    cmd(1'b1, 8'h0F, 8'h01, 80'h01);
    exp_rsp('{8'h10, 8'h0F, 8'h01, 8'hB4, 8'h35}, 5);
    chk({hq[5], hq[6]}, 16'hF4B7);
    chk(st, 8'h01);
    chk(rok, 1'b1);
    chk(nw, 1);
  endtask
  task automatic t_wuser();
    cmd(1'b1, 8'h10, 8'h02, 80'h0201);
    exp_rsp('{8'h10, 8'h10, 8'h02, 8'hFC, 8'h04}, 5);
    chk({hq[6], hq[7]}, 16'hC092);
    chk(u1, 16'h0102);
  endtask
  // Rows: write, start, count, expected second reply byte
  task automatic t_errs();
    logic [7:0] t [8][4] = '{'{8'h0, 8'h1E, 8'h04, 8'h81}, '{8'h0, 8'h00, 8'h0B, 8'h81},
      '{8'h0, 8'h16, 8'h0A, 8'h0A}, '{8'h1, 8'h00, 8'h01, 8'h84}, '{8'h1, 8'h14, 8'h01, 8'h84},
      '{8'h1, 8'h0F, 8'h02, 8'h84}, '{8'h1, 8'h10, 8'h00, 8'h82}, '{8'h1, 8'h13, 8'h01, 8'h13}};
    foreach (t[i])
    begin
      cmd(t[i][0][0], t[i][1], t[i][2], 80'h0);
      chk(rq[1], t[i][3]);
      chk(ne1, {15'h0, t[i][3][7]});
      if (t[i][3][7]) chk(ec1, t[i][3]);
    end
    chk(st, 8'h01);
    cmd(1'b1, 8'h12, 8'h02, 80'hCDAB);
    chk(ne1, 0);
    chk(u2, 16'hABCD);
  endtask
  task automatic t_bad();
    raw('{8'hB9, 8'h03, 8'h00, 8'h02});
    repeat (12) @(posedge clk);
    chk(n2, 0);
    raw('{8'hB8, 8'h04, 8'h00, 8'h01});
    wt2();
    chk(ec2, 8'h80);
    raw('{8'hB8, 8'h10, 8'h0F, 8'h01, 8'h01, 8'hF4, 8'hB6});
    wt2();
    chk(ec2, 8'h83);
  endtask
  initial
  begin
    ln2.h2d_valid <= 1'b0;
    ln2.h2d_data <= 8'h00;
    ln2.h2d_first <= 1'b0;
    ln2.h2d_last <= 1'b0;
    ln2.d2h_ready <= 1'b1;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_hum();
    t_info();
    t_wstat();
    t_wuser();
    t_errs();
    t_bad();
    complete_run();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule
